//--- ebw_ctrl.sv
// External bus access controller with wait-input extension
//
// Contract
// - Wait seen on the first edge extends the access; release resumes cleanly.
// - Wait seen while standard wait states remain delays the access correctly.
// - Late wait in a word read captures first half at unextended end.
// - Late word read: both read pulses stretched, second half captured correctly.
// - Late write: chip select follows wait, write strobe rises at standard end.
// - Late wait leaves byte and half-word read capture correct.
`timescale 1ns/100ps
`default_nettype none
`include "ebw_map.svh"
module ebw_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [2:0] req_ws,
    input wire logic [31:0] wr_data,
    input wire logic [15:0] data_in,
    input wire logic ext_wait_n,
    output logic req_ready,
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic rd_capture,
    output logic [31:0] rd_data,
    output logic done
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    ebw_if u_if ();

    ebw_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .ext_wait_n(ext_wait_n),
        .data_in(data_in),
        .sif(u_if)
    );

    // ----------------------------------------------------------------
    // State and access registers
    // ----------------------------------------------------------------
    ebw_pkg::ebw_state_e state_q, state_d;
    ebw_pkg::ebw_ws_t ws_q, cyc_q, cyc_d;
    ebw_pkg::ebw_size_t size_q;
    logic write_q;
    logic half_q, half_d;
    logic early_q, early_d;
    logic late_q, late_d;
    logic [31:0] wdata_q;
    logic wait_act;
    logic is_word;
    logic last_std;
    logic late_now;
    logic half_end;
    logic cap_d;
    logic done_d;
    logic write_d;
    logic [31:0] wdata_d;

    assign wait_act = u_if.wait_active;
    assign is_word = (size_q == `EBW_SIZE_WORD);
    assign last_std = (cyc_q == ws_q);
    // Wait first seen on the last standard cycle, not the first edge
    assign late_now = (state_q == ebw_pkg::EBW_ST_ACC) && wait_act && last_std
                      && (cyc_q != `EBW_FIRST_CYCLE) && !early_q;
    assign half_end = (state_q == ebw_pkg::EBW_ST_ACC) && !wait_act && last_std;
    // New direction and data must steer the very first strobe cycle, not the old access
    assign write_d = ((state_q == ebw_pkg::EBW_ST_IDLE) && req_valid) ? req_write : write_q;
    assign wdata_d = ((state_q == ebw_pkg::EBW_ST_IDLE) && req_valid) ? wr_data : wdata_q;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Standard cycles count up; a sampled wait freezes the count
    always_comb begin
        state_d = state_q;
        cyc_d = cyc_q;
        half_d = half_q;
        early_d = early_q;
        late_d = late_q;
        done_d = 1'b0;
        case (state_q)
            ebw_pkg::EBW_ST_IDLE: begin
                if (req_valid) begin
                    state_d = ebw_pkg::EBW_ST_ACC;
                    cyc_d = `EBW_FIRST_CYCLE;
                    half_d = 1'b0;
                    early_d = 1'b0;
                    late_d = 1'b0;
                end
            end
            ebw_pkg::EBW_ST_ACC: begin
                if (wait_act) begin
                    // Hold the cycle while wait is asserted
                    if ((cyc_q == `EBW_FIRST_CYCLE) || !last_std) begin
                        early_d = 1'b1;
                    end
                    if (late_now) begin
                        late_d = 1'b1;
                    end
                end else if (!last_std) begin
                    cyc_d = cyc_q + `EBW_CYCLE_STEP;
                end else if (is_word && !half_q) begin
                    state_d = ebw_pkg::EBW_ST_GAP;
                end else begin
                    state_d = ebw_pkg::EBW_ST_IDLE;
                    done_d = 1'b1;
                end
            end
            ebw_pkg::EBW_ST_GAP: begin
                // Second half restarts its own standard count and wait history
                state_d = ebw_pkg::EBW_ST_ACC;
                cyc_d = `EBW_FIRST_CYCLE;
                half_d = 1'b1;
                early_d = 1'b0;
                late_d = 1'b0;
            end
            default: begin
                state_d = ebw_pkg::EBW_ST_IDLE;
            end
        endcase
    end

    // Capture strobe: early first-half sample is the known late-wait flaw
    always_comb begin
        cap_d = 1'b0;
        if (!write_q) begin
            if (late_now && !late_q && is_word && !half_q) begin
                cap_d = 1'b1;
            end else if (half_end && !(late_q && is_word && !half_q)) begin
                cap_d = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ebw_pkg::EBW_ST_IDLE;
            cyc_q <= `EBW_RST_WS;
            half_q <= 1'b0;
            early_q <= 1'b0;
            late_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cyc_q <= cyc_d;
            half_q <= half_d;
            early_q <= early_d;
            late_q <= late_d;
        end
    end

    // Request latch; only taken while idle so a running access is never altered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ws_q <= `EBW_RST_WS;
            size_q <= `EBW_RST_SIZE;
            write_q <= 1'b0;
            wdata_q <= `EBW_RST_DATA32;
        end else if ((state_q == ebw_pkg::EBW_ST_IDLE) && req_valid) begin
            ws_q <= req_ws;
            size_q <= req_size;
            write_q <= req_write;
            wdata_q <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------
    // Outputs follow the next state so each is a plain flop of it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_ready <= 1'b0;
            chip_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            data_oe <= 1'b0;
            data_out <= `EBW_RST_DATA16;
        end else begin
            req_ready <= (state_d == ebw_pkg::EBW_ST_IDLE);
            chip_select_n <= (state_d == ebw_pkg::EBW_ST_IDLE);
            read_strobe_n <= !((state_d == ebw_pkg::EBW_ST_ACC) && !write_d);
            // Late wait cuts the write pulse at the standard end
            write_strobe_n <= !((state_d == ebw_pkg::EBW_ST_ACC) && write_d && !late_d);
            data_oe <= (state_d != ebw_pkg::EBW_ST_IDLE) && write_d;
            data_out <= half_d ? wdata_d[31:16] : wdata_d[15:0];
        end
    end

    // Read data assembly, low half first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_capture <= 1'b0;
            rd_data <= `EBW_RST_DATA32;
            done <= 1'b0;
        end else begin
            rd_capture <= cap_d;
            done <= done_d;
            if (cap_d && half_q) begin
                rd_data[31:16] <= u_if.data;
            end else if (cap_d) begin
                rd_data[15:0] <= u_if.data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_cs_tracks_state;
        @(posedge ref_clk) disable iff (rst)
        $rose(chip_select_n) |-> $past(!wait_act);
    endproperty
    a_cs_tracks_state: assert property (p_cs_tracks_state) else $error("chip select off state");

    property p_wait_holds;
        @(posedge ref_clk) disable iff (rst)
        ((state_q == ebw_pkg::EBW_ST_ACC) && wait_act)
            |=> ((state_q == ebw_pkg::EBW_ST_ACC) && (cyc_q == $past(cyc_q)));
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("wait did not hold cycle");

    property p_early_no_capture;
        @(posedge ref_clk) disable iff (rst)
        ((state_q == ebw_pkg::EBW_ST_ACC) && wait_act && early_q)
            |=> !rd_capture;
    endproperty
    a_early_no_capture: assert property (p_early_no_capture) else $error("capture in hold");

    property p_late_word_capture;
        @(posedge ref_clk) disable iff (rst)
        (late_now && !late_q && is_word && !half_q && !write_q)
            |=> (rd_capture && (rd_data[15:0] == $past(u_if.data)));
    endproperty
    a_late_word_capture: assert property (p_late_word_capture) else $error("no early capture");

    property p_read_pulse_stretch;
        @(posedge ref_clk) disable iff (rst)
        ((state_q == ebw_pkg::EBW_ST_ACC) && wait_act && !write_q && !last_std)
            |=> !read_strobe_n [*2];
    endproperty
    a_read_pulse_stretch: assert property (p_read_pulse_stretch) else $error("read pulse short");

    property p_late_write_cut;
        @(posedge ref_clk) disable iff (rst)
        (late_now && write_q) |=> (write_strobe_n && !chip_select_n);
    endproperty
    a_late_write_cut: assert property (p_late_write_cut) else $error("write strobe not cut");

    property p_short_read_ok;
        @(posedge ref_clk) disable iff (rst)
        (late_now && !is_word && !write_q) |=> !rd_capture;
    endproperty
    a_short_read_ok: assert property (p_short_read_ok) else $error("short read sampled early");

    property p_gap_two_pulses;
        @(posedge ref_clk) disable iff (rst)
        (state_q == ebw_pkg::EBW_ST_GAP) |-> (read_strobe_n || write_q) ##1 !chip_select_n;
    endproperty
    a_gap_two_pulses: assert property (p_gap_two_pulses) else $error("halves not split");

    property p_no_done_in_wait;
        @(posedge ref_clk) disable iff (rst)
        ((state_q == ebw_pkg::EBW_ST_ACC) && wait_act) |=> !done;
    endproperty
    a_no_done_in_wait: assert property (p_no_done_in_wait) else $error("done during wait");
endmodule
`default_nettype wire

//--- ebw_map.svh
// Constants of the wait-extension bus access unit
`ifndef EBW_MAP_SVH
`define EBW_MAP_SVH
// ----------------------------------------------------------------
// Access size codes
// ----------------------------------------------------------------
`define EBW_SIZE_BYTE 2'h0
`define EBW_SIZE_HALF 2'h1
`define EBW_SIZE_WORD 2'h2
// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define EBW_SYNC_WIDTH 17
`define EBW_SYNC_WAIT_BIT 16
`define EBW_HALF_WIDTH 16
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EBW_SYNC_RST 17'h1_0000
`define EBW_RST_DATA32 32'h0000_0000
`define EBW_RST_DATA16 16'h0000
`define EBW_RST_WS 3'h0
`define EBW_RST_SIZE 2'h0
// ----------------------------------------------------------------
// Timing counts, in standard access cycles
// ----------------------------------------------------------------
`define EBW_FIRST_CYCLE 3'h0
`define EBW_CYCLE_STEP 3'h1
`endif

//--- ebw_pkg.sv
// Types of the wait-extension bus access unit
package ebw_pkg;
    typedef enum logic [1:0] {
        EBW_ST_IDLE,
        EBW_ST_ACC,
        EBW_ST_GAP
    } ebw_state_e;
    typedef logic [1:0] ebw_size_t;
    typedef logic [2:0] ebw_ws_t;
endpackage

//--- ebw_if.sv
// Carrier for synchronised pin values between the pin stage and the controller
`timescale 1ns/100ps
`default_nettype none
interface ebw_if;
    logic wait_active;
    logic [15:0] data;
    modport src (output wait_active, output data);
    modport dst (input wait_active, input data);
endinterface
`default_nettype wire

//--- ebw_pin_sync.sv
// Two-stage synchronisers for the wait and data pins
`timescale 1ns/100ps
`default_nettype none
`include "ebw_map.svh"
module ebw_pin_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ext_wait_n,
    input wire logic [15:0] data_in,
    ebw_if.src sif
);
    // ----------------------------------------------------------------
    // Synchroniser stages
    // ----------------------------------------------------------------
    localparam logic [`EBW_SYNC_WIDTH-1:0] SYNC_RST = `EBW_SYNC_RST;
    logic [`EBW_SYNC_WIDTH-1:0] pin_bus;
    logic [`EBW_SYNC_WIDTH-1:0] sync_bus;

    assign pin_bus = {ext_wait_n, data_in};

    // One pair of flops per pin; only the second stage is read
    genvar gi;
    generate
        for (gi = 0; gi < `EBW_SYNC_WIDTH; gi = gi + 1) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    meta_q <= SYNC_RST[gi];
                    sync_q <= SYNC_RST[gi];
                end else begin
                    meta_q <= pin_bus[gi];
                    sync_q <= meta_q;
                end
            end
            // Each bit has its own flops, so the vector has one driver per bit
            assign sync_bus[gi] = sync_q;
        end
    endgenerate

    // Wait pin is active low; carrier holds the active-high sense
    assign sif.wait_active = ~sync_bus[`EBW_SYNC_WAIT_BIT];
    assign sif.data = sync_bus[`EBW_HALF_WIDTH-1:0];
endmodule
`default_nettype wire

//--- ebw_mem_model.sv
// External memory model that returns read data and stretches accesses by wait
`timescale 1ns/100ps
`default_nettype none
module ebw_mem_model (
    input wire logic ref_clk,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic wait_en,
    input wire logic [2:0] wait_len,
    input wire logic [31:0] rd_word,
    output logic ext_wait_n,
    output logic [15:0] data_in
);
    logic strb_q = 1'b0;
    logic half_q = 1'b0;
    logic [2:0] wl = 3'h0;
    logic strb;
    assign strb = !(read_strobe_n && write_strobe_n);
    initial begin
        ext_wait_n = 1'b1;
        data_in = 16'h0000;
    end
    // Pins move on the falling edge; wait is pulled from the first low strobe cycle
    always @(negedge ref_clk) begin
        if (strb && !strb_q && wait_en) begin
            wl = wait_len;
        end
        ext_wait_n <= (wl == 3'h0);
        if (wl != 3'h0) begin
            wl = wl - 3'h1;
        end
        // Deselected bus shows the inverse of its last value, never a stale copy
        if (chip_select_n) begin
            half_q <= 1'b0;
            data_in <= ~data_in;
        end else begin
            data_in <= half_q ? rd_word[31:16] : rd_word[15:0];
            if (!strb && strb_q) begin
                half_q <= 1'b1;
            end
        end
        strb_q <= strb;
    end
endmodule
`default_nettype wire

//--- ext_bus_wait_extension_bench.sv
// Self-checking bench for the wait-extended external access unit
`timescale 1ns/100ps
`default_nettype none
module ext_bus_wait_extension_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [1:0] req_size = 2'h0;
    logic [2:0] req_ws = 3'h0;
    logic [31:0] wr_data = 32'h0000_0000;
    logic [15:0] data_in, data_out;
    logic ext_wait_n, req_ready, chip_select_n, read_strobe_n, write_strobe_n;
    logic data_oe, rd_capture, done, wait_en = 1'b0;
    logic [2:0] wait_len = 3'h1;
    logic [31:0] rd_data, rd_word = 32'h0000_0000;
    int failures = 0;
    int check_count = 0;
    int cs_cnt = 0;
    int rd_cnt = 0;
    int wr_cnt = 0;
    logic [3:0] caps = 4'h0;
    logic [3:0] early = 4'h0;
    logic [16:0] wd;
    logic [71:0] e;
    logic [31:0] q_cs[$];
    logic [23:0] q_pl[$];
    logic [71:0] q_acc[$];

    ebw_ctrl ebw_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_size(req_size), .req_ws(req_ws), .wr_data(wr_data),
        .data_in(data_in), .ext_wait_n(ext_wait_n), .req_ready(req_ready),
        .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .data_out(data_out), .data_oe(data_oe),
        .rd_capture(rd_capture), .rd_data(rd_data), .done(done));
    ebw_mem_model ebw_mem_model_inst (.ref_clk(ref_clk), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .wait_en(wait_en), .wait_len(wait_len), .rd_word(rd_word),
        .ext_wait_n(ext_wait_n), .data_in(data_in));

    // Clock at 10 MHz
    always #50 ref_clk = ~ref_clk;

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One access: note every expected result, then request on a falling edge
    task automatic acc(input logic wr, input logic [1:0] sz, input logic [2:0] ws,
        input logic we, input logic [2:0] len, input int hold);
        int nh, hl, n;
        logic [31:0] wd32, m;
        nh = (sz == 2'h2) ? 2 : 1;
        hl = 1 + ws + (we ? len : 0);
        wd32 = $urandom;
        m = wr ? 32'h0 : (sz == 2'h2) ? '1 : (sz == 2'h0) ? 32'h0000_00ff : 32'h0000_ffff;
        n = 0;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        // A unit that never frees counts against the run
        if (req_ready !== 1'b1) begin
            failures++;
        end
        // Memory word changes only once the previous access is over
        rd_word = $urandom;
        for (int h = 0; h < nh; h++) begin
            n = (wr && we && ws == 3'h2) ? 1 + ws : hl;
            q_pl.push_back({7'(n), wr, wr ? wd32[16*h +: 16] : 16'h0000});
        end
        q_cs.push_back(32'(nh * hl + nh - 1));
        q_acc.push_back({m, rd_word & m, 4'(wr ? 0 : nh), 4'(!wr && nh == 2 && we && ws == 2)});
        req_valid = 1'b1;
        req_write = wr;
        req_size = sz;
        req_ws = ws;
        wr_data = wd32;
        wait_en = we;
        wait_len = len;
        repeat (1 + hold) @(negedge ref_clk);
        req_valid = 1'b0;
        @(negedge ref_clk);
    endtask

    // Watch outputs on the falling edge, where every register has settled
    always @(negedge ref_clk) begin
        if (rd_capture) begin
            caps++;
            early += 4'(!read_strobe_n);
        end
        if (!read_strobe_n) begin
            rd_cnt++;
        end else if (rd_cnt != 0) begin
            chk({rd_cnt[6:0], 17'h0}, q_pl.size() ? q_pl.pop_front() : '1);
            rd_cnt = 0;
        end
        if (!write_strobe_n) begin
            wr_cnt++;
            wd = {data_oe, data_out};
        end else if (wr_cnt != 0) begin
            chk({wr_cnt[6:0], wd}, q_pl.size() ? q_pl.pop_front() : '1);
            wr_cnt = 0;
        end
        if (!chip_select_n) begin
            cs_cnt++;
        end else if (cs_cnt != 0) begin
            chk(cs_cnt, q_cs.size() ? q_cs.pop_front() : '1);
            cs_cnt = 0;
        end
        if (done) begin
            e = q_acc.size() ? q_acc.pop_front() : '1;
            chk({e[71:40], rd_data & e[71:40], caps, early}, e);
            caps = 4'h0;
            early = 4'h0;
        end
    end

    // Watchdog, far beyond the expected run length
    initial begin
        #3000000;
        failures++;
        report_and_stop;
    end

    // Main sequence: directed corners, then random traffic
    initial begin
        void'($urandom(32'hbb07_2354));
        repeat (8) @(negedge ref_clk);
        chk({req_ready, chip_select_n, read_strobe_n, write_strobe_n, data_oe, done, rd_data},
            {6'b011100, 32'h0});
        rst = 1'b0;
        @(negedge ref_clk);
        acc(1'b0, 2'h1, 3'h2, 1'b0, 3'h0, 0);
        acc(1'b0, 2'h2, 3'h2, 1'b0, 3'h0, 0);
        acc(1'b1, 2'h2, 3'h2, 1'b0, 3'h0, 2); // Valid held while busy is ignored
        acc(1'b0, 2'h2, 3'h3, 1'b1, 3'h4, 0);
        acc(1'b1, 2'h1, 3'h3, 1'b1, 3'h2, 0);
        acc(1'b0, 2'h2, 3'h2, 1'b1, 3'h3, 0);
        acc(1'b1, 2'h2, 3'h2, 1'b1, 3'h2, 0);
        acc(1'b1, 2'h0, 3'h2, 1'b1, 3'h1, 0);
        acc(1'b0, 2'h0, 3'h2, 1'b1, 3'h2, 0);
        acc(1'b0, 2'h1, 3'h2, 1'b1, 3'h4, 0);
        acc(1'b0, 2'h3, 3'h2, 1'b0, 3'h0, 0); // Data pins need two cycles to pass their flops
        acc(1'b1, 2'h3, 3'h1, 1'b0, 3'h0, 0);
        acc(1'b1, 2'h3, 3'h0, 1'b0, 3'h0, 0);
        // Wait users keep two standard wait states or more
        for (int i = 0; i < 30; i++) begin
            acc(1'($urandom), 2'($urandom % 3), 3'(2 + $urandom % 2), 1'($urandom),
                3'(1 + $urandom % 4), 0);
        end
        for (int i = 0; i < 200 && q_acc.size() != 0; i++) begin
            @(negedge ref_clk);
        end
        chk(q_acc.size() + q_cs.size() + q_pl.size(), 0);
        report_and_stop;
    end
endmodule
`default_nettype wire
